/* bench/srpf_client_tb.sv */
// Purpose: Self-checking bench for the packet client.
// Assumes: Server model on the link side.
// Notes: Short reply timeout for simulation.
module srpf_client_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] EV = 8'h1e;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  logic [7:0] req_routine = 8'h00;
  logic [7:0] req_byte_param = 8'h00;
  logic [31:0] req_word_param = 32'h0;
  logic [1:0] mode = 2'h0;
  logic slow = 1'b0;
  logic [6:0] ev_n = 7'h0;
  logic req_ready, tx_valid, tx_ready, rx_valid;
  logic rsp_valid, rsp_mismatch, rsp_length_error, rsp_timeout, rsp_data_valid;
  logic [7:0] tx_data, rx_data, rsp_routine, rsp_length, rsp_byte_param, rsp_data, rsp_data_index;
  logic [31:0] rsp_word_param;
  logic [6:0] rsp_event_count;
  logic [71:0] req_frame;
  int errors = 0;
  int cmp_count = 0;
  int ns [3] = '{0, 72, 73};

  // Clock
  always #4 clock = ~clock;

  srpf_client #(.GET_EVENTS_CALL(EV), .TIMEOUT_CYCLES(300)) DUT (
    .clock(clock), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_routine(req_routine), .req_byte_param(req_byte_param), .req_word_param(req_word_param),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data),
    .rsp_valid(rsp_valid), .rsp_routine(rsp_routine), .rsp_length(rsp_length),
    .rsp_byte_param(rsp_byte_param), .rsp_word_param(rsp_word_param), .rsp_mismatch(rsp_mismatch),
    .rsp_length_error(rsp_length_error), .rsp_event_count(rsp_event_count), .rsp_timeout(rsp_timeout),
    .rsp_data_valid(rsp_data_valid), .rsp_data(rsp_data), .rsp_data_index(rsp_data_index)
  );

  srpf_server_model #(.EV_CALL(EV)) server (
    .clock(clock), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
    .rx_data(rx_data), .mode(mode), .slow(slow), .ev_n(ev_n), .req_frame(req_frame)
  );

  // Compare and count
  task automatic check(input logic [71:0] got, input logic [71:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Closing report
  task automatic give_verdict();
    $display("comparisons=%0d mismatches=%0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // One request and its outcome
  task automatic call(input logic [7:0] r, input logic [7:0] b, input logic [31:0] w, input logic reply,
                      input logic [1:0] md, input logic sl, input logic [6:0] en);
    logic [7:0] s;
    int k;
    s = r + 8'h05 + b + w[31:24] + w[23:16] + w[15:8] + w[7:0];
    @(posedge clock);
    #1 req_valid = 1'b1;
    req_routine = r;
    req_byte_param = b;
    req_word_param = w;
    mode = md;
    slow = sl;
    ev_n = en;
    k = 0;
    while (req_ready !== 1'b1 && k < 50) begin
      @(posedge clock);
      #1 k++;
    end
    if (k == 50) begin
      errors++;
      give_verdict();
    end
    @(posedge clock);
    #1 req_valid = 1'b0;
    k = 0;
    while (k < 1000) begin
      @(posedge clock);
      #1 k++;
      if (rsp_valid === 1'b1 || rsp_timeout === 1'b1) break;
    end
    if (k == 1000) begin
      errors++;
      give_verdict();
    end
    check(req_frame, {8'hac, 8'(~s + 8'h01), r, 8'h05, b, w});
    check({rsp_valid, rsp_timeout}, {reply, ~reply});
  endtask

  task automatic t_param();
    call(8'h07, 8'h3c, 32'h12345678, 1'b1, 2'h0, 1'b1, 7'h0);
    check({rsp_data_valid, rsp_data, rsp_data_index}, {1'b1, 8'h87, 8'h04});
    check({rsp_routine, rsp_length, rsp_byte_param, rsp_word_param, rsp_mismatch, rsp_length_error},
          {8'h07, 8'h05, 8'h3d, 32'hedcba987, 2'b00});
    $display("param test done");
  endtask

  task automatic t_info();
    call(8'h02, 8'h00, 32'h0, 1'b1, 2'h0, 1'b0, 7'h0);
    check({rsp_length, rsp_length_error, rsp_mismatch}, {8'h10, 2'b00});
    call(8'h08, 8'h05, 32'h0, 1'b1, 2'h0, 1'b1, 7'h0);
    check({rsp_length, rsp_length_error, rsp_mismatch}, {8'h11, 2'b00});
    check({rsp_data_valid, rsp_data, rsp_data_index}, {1'b1, 8'h10, 8'h10});
    $display("info test done");
  endtask

  task automatic t_events();
    for (int i = 0; i < 3; i++) begin
      call(EV, 8'h00, 32'h0, 1'b1, 2'h0, 1'b0, 7'(ns[i]));
      check({rsp_length, rsp_event_count, rsp_length_error}, {8'(ns[i] * 3), 7'(ns[i]), ns[i] == 73});
    end
    $display("events test done");
  endtask

  task automatic t_faults();
    call(8'h10, 8'h01, 32'h1, 1'b1, 2'h1, 1'b0, 7'h0);
    check({rsp_mismatch, rsp_routine}, {1'b1, 8'h50});
    call(8'h1d, 8'hff, 32'hffffffff, 1'b1, 2'h3, 1'b0, 7'h0);
    check({rsp_routine, rsp_byte_param, rsp_word_param}, {8'h1d, 8'h00, 32'h0});
    call(8'h05, 8'h00, 32'h0, 1'b0, 2'h2, 1'b0, 7'h0);
    call(8'h7f, 8'h00, 32'h0, 1'b0, 2'h0, 1'b0, 7'h0);
    $display("fault test done");
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    #1 sys_rst = 1'b0;
    t_param();
    t_info();
    t_events();
    t_faults();
    t_param();
    give_verdict();
  end
endmodule

/* bench/srpf_server_model.sv */
// Purpose: Behavioural packet server facing the client.
// Assumes: Same clock as the client; byte handshakes.
// Notes: mode 1 wrong routine, 2 bad checksum, 3 noise first.
module srpf_server_model #(
  parameter logic [7:0] EV_CALL = 8'h1e
) (
  input wire logic clock,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic [1:0] mode,
  input wire logic slow,
  input wire logic [6:0] ev_n,
  output logic [71:0] req_frame
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] q [$];
  logic [7:0] r, s;
  logic [31:0] w;
  int n, len;
  // Collect one request, then answer it
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h53;
    req_frame = '0;
    forever begin
      n = 0;
      while (n < 9) begin
        @(posedge clock);
        if (tx_valid && tx_ready && (n > 0 || tx_data == 8'hac)) begin
          req_frame = {req_frame[63:0], tx_data};
          n++;
        end
        #1 tx_ready = (n < 9) && (slow ? ~tx_ready : 1'b1);
      end
      s = 8'h00;
      for (int i = 0; i < 8; i++) s += req_frame[8*i +: 8];
      r = req_frame[55:48];
      // Silent drop of bad or unknown requests
      if (s == 8'h00 && req_frame[47:40] == 8'h05 && (r == EV_CALL || (r >= 1 && r <= 29))) begin
        q = {};
        if (r == 8'h02) for (int i = 0; i < 16; i++) q.push_back((i % 8) < 2 ? 8'h61 : 8'h00);
        else if (r == 8'h08) for (int i = 0; i < 17; i++) q.push_back(8'(i));
        else if (r == EV_CALL) for (int i = 0; i < ev_n * 3; i++) q.push_back(8'(i));
        else begin
          w = ~req_frame[31:0];
          q = {req_frame[39:32] + 8'h01, w[31:24], w[23:16], w[15:8], w[7:0]};
        end
        len = q.size();
        r = (mode == 2'h1) ? r ^ 8'h40 : r;
        s = r + 8'(len);
        foreach (q[i]) s += q[i];
        s = (~s + 8'h01) ^ {7'h00, mode == 2'h2};
        q = {8'hac, s, r, 8'(len), q};
        if (mode == 2'h3) q = {8'h00, 8'h5a, q};
        repeat (slow ? 20 : 2) @(posedge clock);
        foreach (q[i]) begin
          @(posedge clock);
          #1 rx_valid = 1'b1;
          rx_data = q[i];
          if (slow) begin
            @(posedge clock);
            #1 rx_valid = 1'b0;
            rx_data = ~q[i];
          end
        end
        @(posedge clock);
        #1 rx_valid = 1'b0;
        rx_data = ~rx_data;
      end
    end
  end
endmodule

/* rtl/srpf_client.sv */
// Purpose: Host-side serial RPC client: frames requests, checks replies.
// Assumes: tx and rx byte streams on the same clock as this block.
// Notes: One request outstanding; reply timeout abandons the call.
`include "srpf_regs.svh"
// Function
// RULE_01 - every packet starts with byte 0xac on both directions
// RULE_02 - receiver drops bytes until the start byte appears
// RULE_03 - header fields are one byte; payload holds 0 to 255 bytes
// RULE_04 - sent checksum is two's complement of 8-bit sum of later bytes
// RULE_05 - received bytes after start, checksum included, must sum to zero
// RULE_06 - length byte gives exact payload count
// RULE_07 - reply routine must match the request routine
// RULE_08 - device runs the routine and sends exactly one reply
// RULE_09 - requests always carry the parameter layout
// RULE_10 - info and event calls reply in their own layouts, others parameters
// RULE_11 - parameter layout is byte then word, length five
// RULE_12 - word parameter travels most significant byte first
// RULE_13 - device drops bad-checksum or unknown-routine packets silently
// RULE_14 - event payload is whole three-byte records, at most 72
// RULE_15 - system info reply length 16, port info reply length 17
// RULE_16 - no reply within one second counts as a link error
// RULE_17 - link order is start, checksum, routine, length, payload
module srpf_client #(
  parameter logic [7:0] GET_EVENTS_CALL = 8'h00,
  parameter int unsigned TIMEOUT_CYCLES = `SRPF_TIMEOUT_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_routine,
  input wire logic [7:0] req_byte_param,
  input wire logic [31:0] req_word_param,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rsp_valid,
  output logic [7:0] rsp_routine,
  output logic [7:0] rsp_length,
  output logic [7:0] rsp_byte_param,
  output logic [31:0] rsp_word_param,
  output logic rsp_mismatch,
  output logic rsp_length_error,
  output logic [6:0] rsp_event_count,
  output logic rsp_timeout,
  output logic rsp_data_valid,
  output logic [7:0] rsp_data,
  output logic [7:0] rsp_data_index
);
  localparam logic [`SRPF_TMR_W-1:0] TMR_LAST = `SRPF_TMR_W'(TIMEOUT_CYCLES - 1);

  srpf_pkg::srpf_tx_state_t q, d;
  srpf_rx_if rxi ();

  srpf_rx_parser u_parser (
    .clock(clock),
    .sys_rst(sys_rst),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rxo(rxi.parser)
  );

  // Byte on the link for each request position
  function automatic logic [7:0] tx_byte(input logic [3:0] i, input logic [7:0] c, input logic [7:0] r,
                                         input logic [7:0] b, input logic [31:0] w);
    case (i)
      4'h0: tx_byte = `SRPF_PACKET_START_MARKER; // see RULE_01
      4'h1: tx_byte = c; // see RULE_17
      4'h2: tx_byte = r;
      4'h3: tx_byte = `SRPF_PARAM_LEN; // see RULE_11
      4'h4: tx_byte = b; // see RULE_09
      4'h5: tx_byte = w[31:24]; // see RULE_12
      4'h6: tx_byte = w[23:16];
      4'h7: tx_byte = w[15:8];
      default: tx_byte = w[7:0];
    endcase
  endfunction

  // Reply length expected from the called routine
  function automatic logic len_bad(input logic [7:0] r, input logic [7:0] l);
    if (r == `SRPF_GET_SYSTEM_INFO_CALL) begin
      len_bad = (l != `SRPF_SYSINFO_LEN); // see RULE_15
    end else if (r == `SRPF_GET_PORT_INFO_CALL) begin
      len_bad = (l != `SRPF_PORTINFO_LEN);
    end else if (r == GET_EVENTS_CALL) begin
      len_bad = (l % `SRPF_EVENT_BYTES != 8'h00) || (l / `SRPF_EVENT_BYTES > `SRPF_EVENT_MAX); // see RULE_14
    end else begin
      len_bad = (l != `SRPF_PARAM_LEN); // see RULE_10
    end
  endfunction

  // Request framing, reply capture and timeout
  always_comb begin
    logic [7:0] s;
    s = req_routine + `SRPF_PARAM_LEN + req_byte_param + req_word_param[31:24] + req_word_param[23:16]
        + req_word_param[15:8] + req_word_param[7:0];
    d = q;
    d.rspv = 1'b0;
    d.tout = 1'b0;
    d.pv = 1'b0;
    case (q.st)
      srpf_pkg::SRPF_IDLE: begin
        d.rdy = 1'b1;
        if (req_valid && q.rdy) begin
          d.rdy = 1'b0;
          d.rtn = req_routine;
          d.p8 = req_byte_param;
          d.p32 = req_word_param;
          d.cks = ~s + 8'h01; // see RULE_04
          d.idx = 4'h0;
          d.txd = `SRPF_PACKET_START_MARKER; // see RULE_01
          d.txv = 1'b1;
          d.st = srpf_pkg::SRPF_SEND;
        end
      end
      srpf_pkg::SRPF_SEND: begin
        if (tx_ready) begin
          if (q.idx == `SRPF_LAST_TX_IDX) begin
            d.txv = 1'b0;
            d.tmr = '0;
            d.st = srpf_pkg::SRPF_WAIT;
          end else begin
            d.idx = q.idx + 4'h1;
            d.txd = tx_byte(q.idx + 4'h1, q.cks, q.rtn, q.p8, q.p32);
          end
        end
      end
      srpf_pkg::SRPF_WAIT: begin
        d.tmr = q.tmr + `SRPF_TMR_W'(1);
        if (rxi.pay_valid) begin
          d.pv = 1'b1;
          d.pb = rxi.pay_byte;
          d.pi = rxi.pay_idx;
          if (rxi.pay_idx == 8'h00) begin
            d.r8 = rxi.pay_byte;
          end else if (rxi.pay_idx < 8'h05) begin
            d.r32 = {q.r32[23:0], rxi.pay_byte}; // see RULE_12
          end
        end
        if (rxi.frame_done && rxi.frame_ok) begin // see RULE_05
          d.rspv = 1'b1;
          d.rrtn = rxi.routine;
          d.rlen = rxi.length;
          d.mism = (rxi.routine != q.rtn); // see RULE_07
          d.lerr = len_bad(q.rtn, rxi.length);
          d.evc = 7'(rxi.length / `SRPF_EVENT_BYTES); // see RULE_14
          d.rdy = 1'b1;
          d.st = srpf_pkg::SRPF_IDLE;
        end else if (q.tmr == TMR_LAST) begin // see RULE_16
          d.tout = 1'b1;
          d.rdy = 1'b1;
          d.st = srpf_pkg::SRPF_IDLE;
        end
      end
      default: d.st = srpf_pkg::SRPF_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign req_ready = q.rdy;
  assign tx_valid = q.txv;
  assign tx_data = q.txd;
  assign rsp_valid = q.rspv;
  assign rsp_routine = q.rrtn;
  assign rsp_length = q.rlen;
  assign rsp_byte_param = q.r8;
  assign rsp_word_param = q.r32;
  assign rsp_mismatch = q.mism;
  assign rsp_length_error = q.lerr;
  assign rsp_event_count = q.evc;
  assign rsp_timeout = q.tout;
  assign rsp_data_valid = q.pv;
  assign rsp_data = q.pb;
  assign rsp_data_index = q.pi;

  // Running sum of sent bytes after the start byte
  logic [7:0] chk_acc;
  always_ff @(posedge clock) begin
    if (sys_rst || q.st != srpf_pkg::SRPF_SEND) begin
      chk_acc <= 8'h00;
    end else if (tx_valid && tx_ready && q.idx != 4'h0) begin
      chk_acc <= chk_acc + tx_data;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_req_taken;
    q.st == srpf_pkg::SRPF_IDLE && req_valid && req_ready;
  endsequence
  sequence s_last_sent;
    q.st == srpf_pkg::SRPF_SEND && q.idx == `SRPF_LAST_TX_IDX && tx_ready;
  endsequence

  property p_start_first;
    s_req_taken |=> tx_valid && tx_data == `SRPF_PACKET_START_MARKER && !req_ready;
  endproperty
  a_start_first: assert property (p_start_first) else $error("request did not open with start byte"); // see RULE_01

  property p_len_five;
    (q.st == srpf_pkg::SRPF_SEND && q.idx == 4'h3) |-> tx_data == `SRPF_PARAM_LEN;
  endproperty
  a_len_five: assert property (p_len_five) else $error("request length byte not five"); // see RULE_11

  property p_cks_zero;
    s_last_sent |-> 8'(chk_acc + tx_data) == 8'h00;
  endproperty
  a_cks_zero: assert property (p_cks_zero) else $error("sent bytes do not sum to zero"); // see RULE_04

  property p_word_msb;
    (q.st == srpf_pkg::SRPF_SEND && q.idx == 4'h5) |-> tx_data == q.p32[31:24];
  endproperty
  a_word_msb: assert property (p_word_msb) else $error("word parameter not sent high byte first"); // see RULE_12

  property p_to_wait;
    s_last_sent |=> q.st == srpf_pkg::SRPF_WAIT && !tx_valid ##1 q.tmr == `SRPF_TMR_W'(1);
  endproperty
  a_to_wait: assert property (p_to_wait) else $error("request did not end after last byte"); // see RULE_17

  property p_mismatch;
    rsp_valid |-> rsp_mismatch == (rsp_routine != q.rtn) && req_ready;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("routine mismatch flag wrong"); // see RULE_07

  property p_timeout;
    rsp_timeout |-> $past(q.tmr) == TMR_LAST && !rsp_valid;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout at wrong count"); // see RULE_16

  property p_evcount;
    rsp_valid |-> rsp_event_count == 7'(rsp_length / `SRPF_EVENT_BYTES);
  endproperty
  a_evcount: assert property (p_evcount) else $error("event count not length over three"); // see RULE_14
endmodule

/* rtl/srpf_pkg.sv */
// Purpose: Types of the serial RPC packet client.
// Assumes: Constants come from srpf_regs.svh.
// Notes: Gray codes along the usual path.
`include "srpf_regs.svh"
package srpf_pkg;
  typedef enum logic [1:0] {
    SRPF_IDLE = 2'h0,
    SRPF_SEND = 2'h1,
    SRPF_WAIT = 2'h3
  } srpf_mst_t;

  typedef enum logic [2:0] {
    SRPF_HUNT = 3'h0,
    SRPF_CKS = 3'h1,
    SRPF_RTN = 3'h3,
    SRPF_LEN = 3'h2,
    SRPF_PAY = 3'h6
  } srpf_rst_t;

  typedef struct packed {
    srpf_rst_t st;
    logic [7:0] cnt;
    logic [7:0] sum;
    logic [7:0] rtn;
    logic [7:0] len;
    logic pv;
    logic [7:0] pb;
    logic [7:0] pi;
    logic done;
    logic ok;
  } srpf_rx_state_t;

  typedef struct packed {
    srpf_mst_t st;
    logic [3:0] idx;
    logic [7:0] txd;
    logic txv;
    logic [7:0] rtn;
    logic [7:0] p8;
    logic [31:0] p32;
    logic [7:0] cks;
    logic [`SRPF_TMR_W-1:0] tmr;
    logic rdy;
    logic rspv;
    logic [7:0] rrtn;
    logic [7:0] rlen;
    logic [7:0] r8;
    logic [31:0] r32;
    logic mism;
    logic lerr;
    logic tout;
    logic [6:0] evc;
    logic pv;
    logic [7:0] pb;
    logic [7:0] pi;
  } srpf_tx_state_t;
endpackage

/* rtl/srpf_regs.svh */
// Purpose: Constants for the serial RPC packet client.
// Assumes: 125 MHz clock, byte-wide link.
// Notes: Definitions only.
`ifndef SRPF_REGS_SVH
`define SRPF_REGS_SVH
`define SRPF_PACKET_START_MARKER 8'hac
`define SRPF_PARAM_LEN 8'h05
`define SRPF_SYSINFO_LEN 8'h10
`define SRPF_PORTINFO_LEN 8'h11
`define SRPF_EVENT_BYTES 8'h03
`define SRPF_EVENT_MAX 8'h48
`define SRPF_GET_SYSTEM_INFO_CALL 8'h02
`define SRPF_GET_PORT_INFO_CALL 8'h08
`define SRPF_LAST_TX_IDX 4'h8
`define SRPF_TIMEOUT_MS 1000
`define SRPF_CLK_KHZ 125000
`define SRPF_TIMEOUT_CYCLES (`SRPF_TIMEOUT_MS * `SRPF_CLK_KHZ)
`define SRPF_TMR_W 27
`endif

/* rtl/srpf_rx_if.sv */
// Purpose: Carries parsed reply frames from parser to client.
// Assumes: Single clock domain.
// Notes: All signals registered in the parser.
interface srpf_rx_if;
  logic pay_valid;
  logic [7:0] pay_byte;
  logic [7:0] pay_idx;
  logic frame_done;
  logic frame_ok;
  logic [7:0] routine;
  logic [7:0] length;
  modport parser (output pay_valid, pay_byte, pay_idx, frame_done, frame_ok, routine, length);
  modport client (input pay_valid, pay_byte, pay_idx, frame_done, frame_ok, routine, length);
endinterface

/* rtl/srpf_rx_parser.sv */
// Purpose: Hunts packet starts and parses reply frames.
// Assumes: rx bytes come from same-clock UART or SPI logic.
// Notes: Payload is streamed before the checksum verdict.
`include "srpf_regs.svh"
module srpf_rx_parser (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  srpf_rx_if.parser rxo
);
  srpf_pkg::srpf_rx_state_t q, d;

  // Frame walk and running sum
  always_comb begin
    logic [7:0] nsum;
    nsum = q.sum + rx_data;
    d = q;
    d.pv = 1'b0;
    d.done = 1'b0;
    if (rx_valid) begin
      case (q.st)
        srpf_pkg::SRPF_HUNT: begin
          if (rx_data == `SRPF_PACKET_START_MARKER) begin // see RULE_02
            d.st = srpf_pkg::SRPF_CKS;
          end
        end
        srpf_pkg::SRPF_CKS: begin
          d.sum = rx_data; // see RULE_05
          d.st = srpf_pkg::SRPF_RTN;
        end
        srpf_pkg::SRPF_RTN: begin
          d.sum = nsum;
          d.rtn = rx_data;
          d.st = srpf_pkg::SRPF_LEN;
        end
        srpf_pkg::SRPF_LEN: begin
          d.sum = nsum;
          d.len = rx_data;
          d.cnt = 8'h00;
          if (rx_data == 8'h00) begin // see RULE_03
            d.done = 1'b1;
            d.ok = (nsum == 8'h00);
            d.st = srpf_pkg::SRPF_HUNT;
          end else begin
            d.st = srpf_pkg::SRPF_PAY;
          end
        end
        srpf_pkg::SRPF_PAY: begin
          d.sum = nsum;
          d.pv = 1'b1;
          d.pb = rx_data;
          d.pi = q.cnt;
          d.cnt = q.cnt + 8'h01;
          if (q.cnt == q.len - 8'h01) begin // see RULE_06
            d.done = 1'b1;
            d.ok = (nsum == 8'h00); // see RULE_05
            d.st = srpf_pkg::SRPF_HUNT;
          end
        end
        default: d.st = srpf_pkg::SRPF_HUNT;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rxo.pay_valid = q.pv;
  assign rxo.pay_byte = q.pb;
  assign rxo.pay_idx = q.pi;
  assign rxo.frame_done = q.done;
  assign rxo.frame_ok = q.ok;
  assign rxo.routine = q.rtn;
  assign rxo.length = q.len;

  property p_hunt_drop;
    @(posedge clock) disable iff (sys_rst)
    (q.st == srpf_pkg::SRPF_HUNT && rx_valid && rx_data != `SRPF_PACKET_START_MARKER)
      |=> q.st == srpf_pkg::SRPF_HUNT;
  endproperty
  a_hunt_drop: assert property (p_hunt_drop) else $error("non-start byte left hunt state"); // see RULE_02

  property p_len_end;
    @(posedge clock) disable iff (sys_rst)
    (q.st == srpf_pkg::SRPF_PAY && rx_valid && q.cnt == q.len - 8'h01) |=> rxo.frame_done && rxo.pay_valid;
  endproperty
  a_len_end: assert property (p_len_end) else $error("frame did not end at its length"); // see RULE_06
endmodule
